// >>> inc/tsr_params.svh
// Offsets, field positions and reset values of the trace stop and range control block
`ifndef TSR_PARAMS_SVH
`define TSR_PARAMS_SVH

// Register byte offsets
`define TSR_OFF_CTRL 12'h000
`define TSR_OFF_STOP_SEL 12'h004
`define TSR_OFF_DSTOP_SEL 12'h008
`define TSR_OFF_DELAY 12'h00C
`define TSR_OFF_CMD 12'h010
`define TSR_OFF_STATUS 12'h014
`define TSR_OFF_CH_CFG 12'h020
`define TSR_OFF_CH_START 12'h030
`define TSR_OFF_CH_STOP 12'h040
`define TSR_CH_STRIDE 12'h004
`define TSR_OFF_MASK 12'hFF0

// Control field positions
`define TSR_CTRL_FREE 0
`define TSR_CTRL_STOP_EN 1
`define TSR_CTRL_DSTOP_EN 2

// Command field positions
`define TSR_CMD_RESTART 0

// Channel configuration fields
`define TSR_CFG_MODE_LO 0
`define TSR_CFG_MODE_HI 1
`define TSR_CFG_CYCLIC 2
`define TSR_CFG_START_LO 4
`define TSR_CFG_START_HI 6
`define TSR_CFG_STOP_LO 8
`define TSR_CFG_STOP_HI 10

// Sizes and reset values
`define TSR_NUM_CH 4
`define TSR_NUM_EVT 8
`define TSR_DELAY_W 16
`define TSR_DELAY_RST 16'h0001
`define TSR_DELAY_ONE 16'h0001
`define TSR_DELAY_ZERO 16'h0000

`endif

// >>> inc/tsr_pkg.sv
// Types shared by the trace stop and range control block
package tsr_pkg;

    // One observed target bus cycle
    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic rw;
    } tsr_cyc_s;

    // Range-trace channel mode field
    typedef enum logic [1:0] {
        TSR_MODE_OFF = 2'h0,
        TSR_MODE_P2P = 2'h1,
        TSR_MODE_RANGE = 2'h2,
        TSR_MODE_EVENT = 2'h3
    } tsr_mode_e;

    // Window state of one channel
    typedef enum logic [2:0] {
        TSR_WIN_ARMED = 3'b001,
        TSR_WIN_OPEN = 3'b010,
        TSR_WIN_SPENT = 3'b100
    } tsr_win_e;

endpackage

// >>> logic/tsr_buf.sv
// Two-entry record buffer with valid and ready on both sides
`timescale 1ns/10ps
module tsr_buf #(
    parameter int WIDTH = 65
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);

    ////////////////////////////////////////////////////////////////////////
    // Storage: head entry drives the output, tail catches a stalled word
    logic [WIDTH-1:0] tail; // Second entry
    logic tail_valid; // Second entry holds a word
    // Push follows the ready flop, so nothing slips in while ready is still low after reset
    wire push = in_valid_i & in_ready_o; // Accepted this cycle
    wire pop = out_valid_o & out_ready_i; // Drained this cycle

    ////////////////////////////////////////////////////////////////////////
    // Ready comes from the tail flag so it is a flop, at the cost of
    // refusing in the cycle in which a full buffer drains
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            out_valid_o <= 1'b0;
            tail_valid <= 1'b0;
            in_ready_o <= 1'b0;
            out_data_o <= '0;
            tail <= '0;
        end
        else
        begin
            if (pop)
            begin
                // Head leaves; tail or new word moves up
                out_valid_o <= tail_valid | push;
                out_data_o <= tail_valid ? tail : in_data_i;
                tail <= in_data_i;
                tail_valid <= tail_valid & push;
                in_ready_o <= ~(tail_valid & push);
            end
            else if (push && !out_valid_o)
            begin
                // Empty buffer: word goes straight to head
                out_valid_o <= 1'b1;
                out_data_o <= in_data_i;
                in_ready_o <= 1'b1;
            end
            else if (push)
            begin
                // Head stalled: park in tail
                tail <= in_data_i;
                tail_valid <= 1'b1;
                in_ready_o <= 1'b0;
            end
            else
            begin
                // Nothing moves
                in_ready_o <= ~tail_valid;
            end
        end
    end

endmodule

// >>> logic/tsr_top.sv
// Trace stop and range control: delayed and plain stop, four range channels
// Operation
// - Delayed stop records delay count more cycles
// - Only selected events trigger enabled delayed stop
// - Plain and delayed stop act independently
// - Four channels, four modes, only without free
// - Disabled channel never affects acquisition
// - Point mode: start address opens, stop closes
// - Cyclic point mode re-arms after stop
// - Range mode records only matching cycles
// - Event mode: start event opens, stop closes
// - Cyclic event mode re-arms after each stop
// - Free trace records from execution, no channels
`timescale 1ns/10ps
`include "tsr_params.svh"
module tsr_top (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic exec_i,
    input wire logic cyc_valid_i,
    output logic cyc_ready_o,
    input wire logic [64:0] cyc_data_i,
    input wire logic [`TSR_NUM_EVT-1:0] evt_hit_i,
    output logic rec_valid_o,
    input wire logic rec_ready_i,
    output logic [64:0] rec_data_o,
    output logic acq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Software-visible settings
    logic free_mode; // Free trace on
    logic stop_en; // Plain stop enabled
    logic dstop_en; // Delayed stop enabled
    logic [`TSR_NUM_EVT-1:0] stop_sel; // Events for plain stop
    logic [`TSR_NUM_EVT-1:0] dstop_sel; // Events for delayed stop
    logic [`TSR_DELAY_W-1:0] delay; // Delay count setting
    logic [11:0] ch_cfg [`TSR_NUM_CH]; // Mode, cyclic, event picks
    logic [31:0] ch_start [`TSR_NUM_CH]; // Point mode start address
    logic [31:0] ch_stop [`TSR_NUM_CH]; // Point mode stop address

    // Acquisition state
    logic halted; // Acquisition stopped until restart
    logic counting; // Delayed stop running
    logic [`TSR_DELAY_W-1:0] cnt; // Remaining delayed records
    logic exec_q; // Execution seen, reloaded from exec_i by restart

    ////////////////////////////////////////////////////////////////////////
    // APB decode: one wait state, every access answered
    wire setup_ok = psel & penable & ~pready; // Access phase, not yet answered
    wire wr_now = psel & penable & pready & pwrite; // Write takes effect
    wire [11:0] ch_off = paddr & `TSR_OFF_MASK; // Channel group base
    wire [1:0] ch_idx = paddr[3:2]; // Channel index within group
    wire hit_ctrl = paddr == `TSR_OFF_CTRL;
    wire hit_ssel = paddr == `TSR_OFF_STOP_SEL;
    wire hit_dsel = paddr == `TSR_OFF_DSTOP_SEL;
    wire hit_delay = paddr == `TSR_OFF_DELAY;
    wire hit_cmd = paddr == `TSR_OFF_CMD;
    wire hit_stat = paddr == `TSR_OFF_STATUS;
    wire hit_cfg = ch_off == `TSR_OFF_CH_CFG && paddr[1:0] == 2'h0;
    wire hit_start = ch_off == `TSR_OFF_CH_START && paddr[1:0] == 2'h0;
    wire hit_stopa = ch_off == `TSR_OFF_CH_STOP && paddr[1:0] == 2'h0;
    wire hit_any = hit_ctrl | hit_ssel | hit_dsel | hit_delay | hit_cmd | hit_stat
        | hit_cfg | hit_start | hit_stopa;
    wire restart = wr_now & hit_cmd & pwdata[`TSR_CMD_RESTART]; // Clear halt, re-arm
    wire cfg_wr = wr_now & hit_cfg; // Channel reconfigured

    // Read mux; undecoded words read zero with an error
    wire [31:0] rd_val =
        hit_ctrl ? {29'h0000_0000, dstop_en, stop_en, free_mode} :
        hit_ssel ? {24'h00_0000, stop_sel} :
        hit_dsel ? {24'h00_0000, dstop_sel} :
        hit_delay ? {16'h0000, delay} :
        hit_stat ? {cnt, 13'h0000, counting, halted, acq_o} :
        hit_cfg ? {20'h0_0000, ch_cfg[ch_idx]} :
        hit_start ? ch_start[ch_idx] :
        hit_stopa ? ch_stop[ch_idx] : 32'h0000_0000;

    // Answer register: pready high for one cycle in the access phase
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= setup_ok;
            pslverr <= setup_ok & ~hit_any;
            prdata <= setup_ok ? rd_val : 32'h0000_0000;
        end
    end

    // Global settings writes
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            free_mode <= 1'b0;
            stop_en <= 1'b0;
            dstop_en <= 1'b0;
            stop_sel <= '0;
            dstop_sel <= '0;
            delay <= `TSR_DELAY_RST;
        end
        else if (wr_now)
        begin
            if (hit_ctrl)
            begin
                free_mode <= pwdata[`TSR_CTRL_FREE];
                stop_en <= pwdata[`TSR_CTRL_STOP_EN];
                dstop_en <= pwdata[`TSR_CTRL_DSTOP_EN];
            end
            else if (hit_ssel)
                stop_sel <= pwdata[`TSR_NUM_EVT-1:0];
            else if (hit_dsel)
                dstop_sel <= pwdata[`TSR_NUM_EVT-1:0];
            // Zero is outside the legal range and is refused
            else if (hit_delay && pwdata[`TSR_DELAY_W-1:0] != `TSR_DELAY_ZERO)
                delay <= pwdata[`TSR_DELAY_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus cycle intake: a cycle counts once the buffer takes its slot
    tsr_pkg::tsr_cyc_s cyc; // Observed bus cycle
    assign cyc = cyc_data_i;
    wire take = cyc_valid_i & cyc_ready_o; // Cycle consumed this edge
    logic [`TSR_NUM_CH-1:0] ch_rec; // Channel wants this cycle
    logic [`TSR_NUM_CH-1:0] ch_on; // Channel not disabled
    logic [`TSR_NUM_CH-1:0] ch_live; // Channel window open or filtering

    ////////////////////////////////////////////////////////////////////////
    // Range-trace channels
    for (genvar g = 0; g < `TSR_NUM_CH; g++)
    begin : g_ch
        tsr_pkg::tsr_mode_e mode;
        tsr_pkg::tsr_win_e win;
        tsr_pkg::tsr_win_e next_win;
        wire cyclic = ch_cfg[g][`TSR_CFG_CYCLIC];
        wire [2:0] sidx = ch_cfg[g][`TSR_CFG_START_HI:`TSR_CFG_START_LO];
        wire [2:0] pidx = ch_cfg[g][`TSR_CFG_STOP_HI:`TSR_CFG_STOP_LO];
        assign mode = tsr_pkg::tsr_mode_e'(ch_cfg[g][`TSR_CFG_MODE_HI:`TSR_CFG_MODE_LO]);
        // Start and stop as single address match or selected event
        wire is_p2p = mode == tsr_pkg::TSR_MODE_P2P;
        wire go = is_p2p ? cyc.addr == ch_start[g] : evt_hit_i[sidx];
        wire end_hit = is_p2p ? cyc.addr == ch_stop[g] : evt_hit_i[pidx];
        wire windowed = is_p2p | mode == tsr_pkg::TSR_MODE_EVENT;
        // Channels only count without free trace
        assign ch_on[g] = ~free_mode & mode != tsr_pkg::TSR_MODE_OFF;
        // Range filter has no window; windowed modes are live only while open
        assign ch_live[g] = ch_on[g] & (mode == tsr_pkg::TSR_MODE_RANGE
            | win == tsr_pkg::TSR_WIN_OPEN);

        // Window state machine
        always_comb
        begin
            next_win = win;
            case (win)
                tsr_pkg::TSR_WIN_ARMED:
                    if (take && windowed && go)
                        next_win = tsr_pkg::TSR_WIN_OPEN;
                tsr_pkg::TSR_WIN_OPEN:
                    if (take && windowed && end_hit)
                        // Cyclic goes back to waiting for start
                        next_win = cyclic ? tsr_pkg::TSR_WIN_ARMED
                            : tsr_pkg::TSR_WIN_SPENT;
                default:
                    next_win = tsr_pkg::TSR_WIN_SPENT;
            endcase
        end

        // The start cycle and the stop cycle are both recorded
        assign ch_rec[g] = ch_on[g] & (mode == tsr_pkg::TSR_MODE_RANGE ? evt_hit_i[sidx]
            : (win == tsr_pkg::TSR_WIN_OPEN) | (win == tsr_pkg::TSR_WIN_ARMED & go));

        // A config write or a restart re-arms the channel
        always_ff @(posedge clk_i or negedge reset_n_i)
        begin
            if (!reset_n_i)
                win <= tsr_pkg::TSR_WIN_ARMED;
            else if (restart || (cfg_wr && ch_idx == 2'(g)))
                win <= tsr_pkg::TSR_WIN_ARMED;
            else
                win <= next_win;
        end

        // Channel settings writes
        always_ff @(posedge clk_i or negedge reset_n_i)
        begin
            if (!reset_n_i)
            begin
                ch_cfg[g] <= 12'h000;
                ch_start[g] <= 32'h0000_0000;
                ch_stop[g] <= 32'h0000_0000;
            end
            else if (wr_now && ch_idx == 2'(g))
            begin
                if (hit_cfg)
                    ch_cfg[g] <= pwdata[11:0];
                else if (hit_start)
                    ch_start[g] <= pwdata;
                else if (hit_stopa)
                    ch_stop[g] <= pwdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Acquisition decision
    wire any_on = |ch_on;
    // Without an active channel, record everything from execution start
    wire want = any_on ? |ch_rec : exec_q;
    wire rec_now = take & want & ~halted; // Cycle goes to the buffer
    wire rec_in = cyc_valid_i & want & ~halted; // Only wanted cycles enter the buffer
    wire plain_stop = stop_en & |(evt_hit_i & stop_sel);
    wire dtrig = dstop_en & |(evt_hit_i & dstop_sel);
    wire dload = rec_now & dtrig & ~counting;
    wire dlast = rec_now & counting & cnt == `TSR_DELAY_ONE;

    // Stop and delay counter; the two stop paths never wait on each other
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            halted <= 1'b0;
            counting <= 1'b0;
            cnt <= `TSR_DELAY_ZERO;
            exec_q <= 1'b0;
        end
        else if (restart)
        begin
            halted <= 1'b0;
            counting <= 1'b0;
            cnt <= `TSR_DELAY_ZERO;
            exec_q <= exec_i;
        end
        else
        begin
            exec_q <= exec_q | exec_i;
            if ((take && plain_stop) || dlast)
                halted <= 1'b1;
            if (dload)
            begin
                counting <= 1'b1;
                cnt <= delay;
            end
            else if (rec_now && counting)
            begin
                // The last delayed record steps the count to zero and ends counting
                counting <= ~dlast;
                cnt <= cnt - `TSR_DELAY_ONE;
            end
        end
    end

    // Acquisition flag for the outside world
    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
            acq_o <= 1'b0;
        else
            acq_o <= ~halted & (any_on ? |ch_live : exec_q);
    end

    ////////////////////////////////////////////////////////////////////////
    // Record buffer; its ready throttles intake
    tsr_buf #(
        .WIDTH(65)
    ) u_buf (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(rec_in),
        .in_ready_o(cyc_ready_o),
        .in_data_i(cyc_data_i),
        .out_valid_o(rec_valid_o),
        .out_ready_i(rec_ready_i),
        .out_data_o(rec_data_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_load;
        dload && !restart;
    endsequence
    sequence s_last;
        dlast && !restart;
    endsequence

    a_delay_load: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        s_load |=> counting && cnt == $past(delay)) else $error("delay not loaded");
    a_delay_halt: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        s_last |=> halted && !counting) else $error("no halt at end of delay");
    a_dsel_gate: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !dstop_en && !restart |=> !counting || $past(counting)) else $error("ungated delay");
    a_plain_stop: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        take && plain_stop && !restart |=> halted) else $error("plain stop missed");
    a_free_chans: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        free_mode |-> ch_on == '0) else $error("channel active in free mode");
    a_halt_quiet: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        halted |-> !rec_now) else $error("record after halt");
    a_cnt_step: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        rec_now && counting && !dlast && !restart |=> cnt == $past(cnt) - 16'h0001)
        else $error("delay count not stepped");
    a_retrig_ign: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        counting && dtrig && rec_now && !dlast && !restart |=> counting && cnt != delay
        || delay == 16'h0001) else $error("retrigger reloaded counter");
    a_apb_answer: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        setup_ok |=> pready ##1 !pready) else $error("pready not single cycle");

endmodule

// >>> tb/tsr_bus_model.sv
// Behavioural target bus that offers observed cycles and drains trace records
`timescale 1ns/10ps
module tsr_bus_model (
    input wire logic clk_i,
    input wire logic cyc_ready_i,
    input wire logic rec_valid_i,
    input wire logic [64:0] rec_data_i,
    input wire logic stall_i,
    output logic cyc_valid_o,
    output logic [64:0] cyc_data_o,
    output logic [7:0] evt_hit_o,
    output logic rec_ready_o
);
    // Records popped from the block, oldest first
    logic [64:0] popq[$];

    ////////////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial
    begin
        cyc_valid_o = 1'b0;
        cyc_data_o = '0;
        evt_hit_o = 8'h00;
        rec_ready_o = 1'b1;
    end

    // Drain follows the stall request one edge late, as a real sink would
    always @(posedge clk_i)
    begin
        if (rec_valid_i && rec_ready_o)
        begin
            popq.push_back(rec_data_i);
        end
        rec_ready_o <= !stall_i;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Offer one read cycle, hold it until taken; ok is low if it never was
    task automatic send(input logic [31:0] addr, input logic [7:0] evt, output logic ok);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_valid_o <= 1'b1;
        cyc_data_o <= tsr_pkg::tsr_cyc_s'{addr: addr, data: ~addr, rw: 1'b1};
        evt_hit_o <= evt;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (cyc_ready_i !== 1'b1 && n < 50);
        ok = cyc_ready_i;
        cyc_valid_o <= 1'b0;
        // Released lines show the inverse, so a stale cycle can never pass
        cyc_data_o <= ~cyc_data_o;
        evt_hit_o <= ~evt;
    endtask
endmodule

// >>> tb/trace_stop_and_range_control_bench.sv
// Self-checking bench of the trace stop and range control block
`timescale 1ns/10ps
`include "tsr_params.svh"
module trace_stop_and_range_control_bench;
    logic clk_i;
    logic reset_n_i;
    logic psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, exec_i, stall;
    logic cyc_valid, cyc_ready, rec_valid, rec_ready, acq;
    logic [64:0] cyc_data, rec_data;
    logic [7:0] evt_hit;
    // Mismatch and comparison counters
    int error_cnt = 0;
    int n_tests = 0;

    tsr_top i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .exec_i(exec_i), .cyc_valid_i(cyc_valid), .cyc_ready_o(cyc_ready),
        .cyc_data_i(cyc_data), .evt_hit_i(evt_hit), .rec_valid_o(rec_valid),
        .rec_ready_i(rec_ready), .rec_data_o(rec_data), .acq_o(acq));

    tsr_bus_model i_bus (.clk_i(clk_i), .cyc_ready_i(cyc_ready), .rec_valid_i(rec_valid),
        .rec_data_i(rec_data), .stall_i(stall), .cyc_valid_o(cyc_valid),
        .cyc_data_o(cyc_data), .evt_hit_o(evt_hit), .rec_ready_o(rec_ready));

    ////////////////////////////////////////////////////////////////////////////////
    // 25 MHz clock
    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // Verdict, reached from the main sequence or the watchdog
    task automatic summarize();
        $display("checks %0d, errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // One comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // APB transfer; waits for pready without assuming a latency
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_i);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_i);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        chk({31'h0, pready}, 32'h0000_0001);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask

    // Read and compare data and error flag
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0000_0000, rd, err);
        chk(rd, exp);
        chk({31'h0, err}, {31'h0, exp_err});
    endtask

    // Offer one bus cycle; a cycle never taken counts as a mismatch
    task automatic put(input logic [31:0] a, input logic [7:0] evt);
        logic ok;
        i_bus.send(a, evt, ok);
        chk({31'h0, ok}, 32'h0000_0001);
    endtask

    // Acquisition state once the taken cycle has landed
    task automatic acq_is(input logic exp);
        repeat (2) @(posedge clk_i);
        chk({31'h0, acq}, {31'h0, exp});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values, unmapped access, start of execution
    task automatic t_reset();
        rd_chk(`TSR_OFF_CTRL, 32'h0000_0000, 1'b0);
        rd_chk(`TSR_OFF_DELAY, 32'h0000_0001, 1'b0);
        rd_chk(`TSR_OFF_CH_CFG, 32'h0000_0000, 1'b0);
        rd_chk(12'h0F0, 32'h0000_0000, 1'b1);
        acq_is(1'b0);
        exec_i <= 1'b1;
        @(posedge clk_i);
        acq_is(1'b1);
    endtask

    // Range filter: only cycles that hit the chosen event are recorded
    task automatic t_range();
        wr(`TSR_OFF_CH_CFG, 32'h0000_0022);
        i_bus.popq.delete();
        put(32'h0000_0050, 8'h04);
        put(32'h0000_0054, 8'h01);
        repeat (4) @(posedge clk_i);
        chk(i_bus.popq.size(), 32'h0000_0001);
        chk(i_bus.popq[0][64:33], 32'h0000_0050);
    endtask

    // Receiver stall: buffer refuses at two words and loses none
    task automatic t_buffer();
        i_bus.popq.delete();
        stall <= 1'b1;
        put(32'h0000_0010, 8'h00);
        put(32'h0000_0014, 8'h00);
        repeat (3) @(posedge clk_i);
        chk({31'h0, cyc_ready}, 32'h0000_0000);
        chk({31'h0, rec_valid}, 32'h0000_0001);
        stall <= 1'b0;
        put(32'h0000_0018, 8'h00);
        repeat (6) @(posedge clk_i);
        chk(i_bus.popq.size(), 32'h0000_0003);
        chk(i_bus.popq[0][64:33], 32'h0000_0010);
        chk(i_bus.popq[0][32:1], 32'hFFFF_FFEF);
        chk(i_bus.popq[2][64:33], 32'h0000_0018);
    endtask

    // Plain stop; delayed-stop selection without its enable does nothing
    task automatic t_plain();
        wr(`TSR_OFF_CTRL, 32'h0000_0002);
        wr(`TSR_OFF_STOP_SEL, 32'h0000_0001);
        wr(`TSR_OFF_DSTOP_SEL, 32'h0000_0002);
        wr(`TSR_OFF_CMD, 32'h0000_0001);
        put(32'h0000_0020, 8'h02);
        rd_chk(`TSR_OFF_STATUS, 32'h0000_0001, 1'b0);
        put(32'h0000_0024, 8'h01);
        rd_chk(`TSR_OFF_STATUS, 32'h0000_0002, 1'b0);
        acq_is(1'b0);
    endtask

    // Delayed stop of three cycles, unselected event and retrigger ignored
    task automatic t_delay();
        wr(`TSR_OFF_DELAY, 32'h0000_0003);
        wr(`TSR_OFF_DELAY, 32'h0000_0000);
        rd_chk(`TSR_OFF_DELAY, 32'h0000_0003, 1'b0);
        wr(`TSR_OFF_CTRL, 32'h0000_0006);
        wr(`TSR_OFF_CMD, 32'h0000_0001);
        put(32'h0000_0030, 8'h04);
        rd_chk(`TSR_OFF_STATUS, 32'h0000_0001, 1'b0);
        put(32'h0000_0034, 8'h02);
        rd_chk(`TSR_OFF_STATUS, 32'h0003_0005, 1'b0);
        put(32'h0000_0038, 8'h02);
        rd_chk(`TSR_OFF_STATUS, 32'h0002_0005, 1'b0);
        put(32'h0000_003C, 8'h00);
        rd_chk(`TSR_OFF_STATUS, 32'h0001_0005, 1'b0);
        put(32'h0000_0040, 8'h00);
        rd_chk(`TSR_OFF_STATUS, 32'h0000_0002, 1'b0);
        acq_is(1'b0);
    endtask

    // Cyclic point window, then free mode, then all channels disabled
    task automatic t_point();
        wr(`TSR_OFF_CTRL, 32'h0000_0000);
        wr(`TSR_OFF_CH_CFG, 32'h0000_0005);
        wr(`TSR_OFF_CH_START, 32'h0000_0100);
        wr(`TSR_OFF_CH_STOP, 32'h0000_0200);
        wr(`TSR_OFF_CMD, 32'h0000_0001);
        put(32'h0000_0300, 8'h00);
        acq_is(1'b0);
        put(32'h0000_0100, 8'h00);
        acq_is(1'b1);
        put(32'h0000_0300, 8'h00);
        acq_is(1'b1);
        put(32'h0000_0200, 8'h00);
        acq_is(1'b0);
        put(32'h0000_0100, 8'h00);
        acq_is(1'b1);
        put(32'h0000_0200, 8'h00);
        acq_is(1'b0);
        wr(`TSR_OFF_CTRL, 32'h0000_0001);
        acq_is(1'b1);
        wr(`TSR_OFF_CTRL, 32'h0000_0000);
        wr(`TSR_OFF_CH_CFG, 32'h0000_0000);
        wr(`TSR_OFF_CMD, 32'h0000_0001);
        acq_is(1'b1);
    endtask

    // Event window on channel one, then cyclic on channel three
    task automatic t_event();
        logic [11:0] a;
        for (int c = 0; c < 2; c++)
        begin
            a = `TSR_OFF_CH_CFG + 12'(1 + 2 * c) * `TSR_CH_STRIDE;
            wr(a, 32'h0000_0323 | (32'(c) << 2));
            wr(`TSR_OFF_CMD, 32'h0000_0001);
            acq_is(1'b0);
            put(32'h0000_0040, 8'h04);
            acq_is(1'b1);
            put(32'h0000_0044, 8'h08);
            acq_is(1'b0);
            put(32'h0000_0048, 8'h04);
            acq_is(c[0]);
            wr(a, 32'h0000_0000);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        reset_n_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        exec_i = 1'b0;
        stall = 1'b0;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_buffer();
        t_plain();
        t_delay();
        t_point();
        t_event();
        t_range();
        summarize();
    end

    // Watchdog well beyond the expected few hundred cycles
    initial
    begin
        repeat (20000) @(posedge clk_i);
        error_cnt++;
        summarize();
    end
endmodule
